// >>> dv/bridge_irq_checker.sv
/*
  port assertions for the bridge interrupt block.
  assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/100ps
module bridge_irq_checker
  import bridge_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic lb_ack_read_i,
  input wire logic lb_ack_retry_o,
  input wire logic lb_ack_done_o,
  input wire logic pci_ack_req_o,
  input wire logic pci_ack_done_i,
  input wire logic [31:0] pci_ack_addr_o,
  input wire logic [3:0] pci_ack_be_n_o,
  input wire logic pci_ack_rd_i,
  input wire logic pci_ack_rd_valid_o,
  input wire logic [31:0] pci_ack_rd_data_o
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_launch_retry: assert property ($rose(pci_ack_req_o) |-> lb_ack_retry_o)
    else $error("ack cycle began without retry");
  a_ack_req_hold: assert property (pci_ack_req_o && !pci_ack_done_i |=>
    pci_ack_req_o && $stable(pci_ack_addr_o) && $stable(pci_ack_be_n_o))
    else $error("ack request moved before done");
  a_ack_req_end: assert property (pci_ack_req_o && pci_ack_done_i |=> !pci_ack_req_o)
    else $error("ack request outlived done");
  a_one_answer: assert property (lb_ack_read_i |=> lb_ack_retry_o != lb_ack_done_o)
    else $error("ack attempt not answered once");
  a_busy_retry: assert property (lb_ack_read_i && pci_ack_req_o && !pci_ack_done_i |=> lb_ack_retry_o)
    else $error("attempt during cycle not retried");
  a_pci_read_zero: assert property (pci_ack_rd_i |=> pci_ack_rd_valid_o && pci_ack_rd_data_o == WORD_ZERO)
    else $error("pci read of ack register wrong");
  a_b_single: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  a_r_single: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read response repeated");
endmodule // bridge_irq_checker
bind bridge_interrupt_and_iack_logic bridge_irq_checker u_chk (.*);

// >>> dv/pci_ack_target.sv
/*
  far side: pci target that answers acknowledge cycles.
  assumes the block holds its request until done.
*/
`timescale 1ns/100ps
module pci_ack_target (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [7:0] delay_i,
  input wire logic [31:0] ans_i,
  output logic done_o,
  output logic [31:0] data_o
);
  // ----------------------------------------
  // target response
  // ----------------------------------------
  logic [7:0] cnt = 8'h00;
  initial done_o = 1'h0;
  initial data_o = 32'h5A5A_A5A5;
  always @(posedge clk_i) begin
    done_o <= 1'h0;
    // released bus toggles, stale data never matches
    data_o <= ~data_o;
    if (!rst_n_i || !req_i || done_o) begin
      cnt <= 8'h00;
    end else if (cnt >= delay_i) begin
      done_o <= 1'h1;
      data_o <= ans_i;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // pci_ack_target

// >>> dv/tb_top.sv
/*
  self-checking bench for the bridge interrupt block.
  assumes the target model and the bound checker.
*/
`timescale 1ns/100ps
module tb_top;
  import bridge_irq_pkg::*;
  // ----------------------------------------
  // signals, instances, bus tasks
  // ----------------------------------------
  logic clk_i = '0, rst_n_i = '0, s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
  logic s_axi_arvalid_i = '0, s_axi_rready_i = '0, eeprom_load_i = '0, lb_ack_read_i = '0, pci_ack_rd_i = '0;
  logic [31:0] s_axi_awaddr_i = '0, s_axi_wdata_i = '0, s_axi_araddr_i = '0, lb_ack_addr_i = '0, ans = '0;
  logic [3:0] s_axi_wstrb_i = 4'hF, pci_ack_be_n_o, snap_be;
  logic [1:0] transfer_size_bits_i = '0, s_axi_bresp_o, s_axi_rresp_o;
  logic [NUM_EVT-1:0] event_pulse_i = '0;
  logic [7:0] eeprom_int_pin_i = '0, delay = '0;
  logic [4:0] cerr = '0;
  logic [31:0] pci_ack_data_i, s_axi_rdata_o, lb_ack_data_o, pci_ack_addr_o, pci_ack_rd_data_o, snap_addr;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, pci_int_o;
  logic pci_int_oe_n_o, local_bus_irq_out_n_o, lb_ack_retry_o, lb_ack_done_o, pci_ack_req_o;
  logic pci_ack_rd_valid_o, pci_ack_done_i, snap_req;
  wire logic detected_parity_err_i = cerr[0];
  wire logic signalled_system_err_i = cerr[1];
  wire logic received_master_abort_i = cerr[2];
  wire logic received_target_abort_i = cerr[3];
  wire logic signalled_target_abort_i = cerr[4];
  int n_errors = 0;
  int n_checks = 0;
  always #10 clk_i = ~clk_i;
  bridge_interrupt_and_iack_logic dut (.*);
  pci_ack_target far (.clk_i, .rst_n_i, .req_i(pci_ack_req_o), .delay_i(delay), .ans_i(ans),
    .done_o(pci_ack_done_i), .data_o(pci_ack_data_i));
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tr;
    s_axi_awaddr_i <= {24'h0, a};
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= '1;
    s_axi_wvalid_i <= '1;
    s_axi_bready_i <= '1;
    do begin
      @(negedge clk_i);
      ta = s_axi_awvalid_i & s_axi_awready_o;
      tw = s_axi_wvalid_i & s_axi_wready_o;
      tr = s_axi_bvalid_o;
      if (tr) chk(s_axi_bresp_o, er);
      @(posedge clk_i);
      if (ta) s_axi_awvalid_i <= '0;
      if (tw) s_axi_wvalid_i <= '0;
    end while (!tr);
    s_axi_bready_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    logic ta, tr;
    s_axi_araddr_i <= {24'h0, a};
    s_axi_arvalid_i <= '1;
    s_axi_rready_i <= '1;
    do begin
      @(negedge clk_i);
      ta = s_axi_arvalid_i & s_axi_arready_o;
      tr = s_axi_rvalid_o;
      if (tr) chk({s_axi_rresp_o, s_axi_rdata_o}, {er, exp});
      @(posedge clk_i);
      if (ta) s_axi_arvalid_i <= '0;
    end while (!tr);
    s_axi_rready_i <= '0;
    @(posedge clk_i);
  endtask
  // outputs settle two edges after their cause
  task automatic irq(input logic p, input logic l);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({pci_int_o, pci_int_oe_n_o, local_bus_irq_out_n_o}, {1'b0, ~p, ~l});
    @(posedge clk_i);
  endtask
  task automatic ack_try(input logic [1:0] s, input logic [1:0] a, output logic d);
    lb_ack_read_i <= '1;
    transfer_size_bits_i <= s;
    lb_ack_addr_i <= {30'h2000_0005, a};
    @(posedge clk_i);
    lb_ack_read_i <= '0;
    @(negedge clk_i);
    d = lb_ack_done_o;
    {snap_req, snap_addr, snap_be} = {pci_ack_req_o, pci_ack_addr_o, pci_ack_be_n_o};
    @(posedge clk_i);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_misc;
    rd(OFS_STATUS, '0);
    rd(OFS_MISC, 32'h0000_0100);
    wr(OFS_MISC, 32'h0000_01FF);
    rd(OFS_MISC, 32'h0000_01FF);
    eeprom_int_pin_i <= 8'h05;
    eeprom_load_i <= '1;
    @(posedge clk_i);
    eeprom_load_i <= '0;
    rd(OFS_MISC, 32'h0000_05FF);
    s_axi_wstrb_i <= 4'h2;
    wr(OFS_MISC, 32'h0000_0733);
    s_axi_wstrb_i <= 4'hF;
    rd(OFS_MISC, 32'h0000_07FF);
    wr(OFS_MISC, 32'h0000_00FF);
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(8'h18, '0, RESP_SLVERR);
    rd(OFS_ENABLE, '0);
  endtask
  task automatic t_soft;
    for (int i = 0; i < NUM_SOFT; i++) begin
      wr(OFS_DIR, 32'(i[0]) << (SOFT_LSB + i));
      wr(OFS_SOFT, 32'(1) << i);
      irq(i[0], !i[0]);
      rd(OFS_STATUS, 32'(1) << (SOFT_LSB + i));
      wr(OFS_SOFT, '0);
      wr(OFS_STATUS, '0);
      irq(i[0], !i[0]);
      wr(OFS_STATUS, 32'(1) << (SOFT_LSB + i));
      irq('0, '0);
    end
  endtask
  task automatic t_evt;
    for (int e = 0; e < NUM_EVT; e++) begin
      wr(OFS_DIR, 32'(e[0]) << e);
      event_pulse_i <= NUM_EVT'(1 << e);
      @(posedge clk_i);
      event_pulse_i <= '0;
      irq('0, '0);
      rd(OFS_STATUS, 32'(1) << e);
      wr(OFS_ENABLE, 32'(1) << e);
      irq(e[0], !e[0]);
      wr(OFS_STATUS, 32'(1) << e);
      irq('0, '0);
      wr(OFS_ENABLE, '0);
    end
  endtask
  task automatic t_cfg;
    wr(OFS_ENABLE, 32'h80);
    for (int k = 0; k < 5; k++) begin
      wr(OFS_DIR, 32'(k[0]) << CFG_BIT);
      cerr <= 5'(1 << k);
      irq(k[0], !k[0]);
      rd(OFS_STATUS, 32'h80);
      cerr <= '0;
      wr(OFS_STATUS, 32'h80);
      irq('0, '0);
    end
    cerr <= 5'h01;
    wr(OFS_STATUS, 32'h80);
    irq('0, '1);
    cerr <= '0;
    wr(OFS_STATUS, 32'h80);
    irq('0, '0);
    wr(OFS_ENABLE, '0);
    wr(OFS_DIR, '0);
  endtask
  task automatic t_ack;
    logic d;
    logic [1:0] a;
    logic [3:0] ln;
    wr(OFS_SOFT, 32'h1);
    for (int k = 0; k < 4; k++) begin
      delay <= 8'(1 + 5 * k);
      ans <= 32'hC0DE_0000 + 32'(k);
      a = 2'((4 - k) % 4);
      ln = (k == 0) ? LANE_LONG : (k == 1) ? LANE_BYTE : (k == 2) ? LANE_HALF : LANE_TRI;
      ln = ~4'(ln << a);
      ack_try(2'(k), a, d);
      chk({d, snap_req}, 2'h1);
      chk(snap_addr, {30'h2000_0005, a});
      chk(snap_be, ln);
      for (int j = 0; j < 60 && !d; j++) ack_try(2'(k), a, d);
      chk({d, lb_ack_data_o}, {1'h1, 32'hC0DE_0000 + 32'(k)});
      rd(OFS_ACK, 32'hC0DE_0000 + 32'(k));
    end
    wr(OFS_ACK, 32'h1234_5678);
    rd(OFS_ACK, 32'hC0DE_0003);
    pci_ack_rd_i <= '1;
    @(posedge clk_i);
    pci_ack_rd_i <= '0;
    @(negedge clk_i);
    chk({pci_ack_rd_valid_o, pci_ack_rd_data_o}, {1'h1, 32'h0});
    @(posedge clk_i);
    irq('0, '1);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= '1;
    t_misc;
    t_soft;
    t_evt;
    t_cfg;
    t_ack;
    complete_run;
  end
endmodule // tb_top

// >>> hdl/bridge_interrupt_and_iack_logic.sv
/*
  interrupt status, enable and steering for the bridge, plus the
  delayed-read acknowledge cycle generator.
  assumes event inputs are one-cycle pulses, config status bits are
  levels, and the pci master and local-bus ports share clk_i.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
// Function
// R1: seven event sources: enable, map, flag each
// R2: four software requests, each map and flag
// R3: soft request sets flag, drives mapped output
// R4: software interrupts ignore enable bits
// R5: soft flag holds until written one
// R6: interrupts never stall acknowledge processing
// R7: config error bits rising set config flag; the code sets it on the level, not the edge
// R8: config interrupt steered by own map bit
// R9: master parity bit kept out of aggregation
// R10: writing one clears config flag, interrupt
// R11: local read of ack register runs cycle
// R12: byte enables from size, low address
// R13: local address passed to pci address
// R14: ack read delayed: retry, latch, return
// R15: local master repeats retried read
// R16: ack writes ignored; pci reads zero
// R17: single pci pin, pin field resets one
// R18: pin field loadable, never gates output
// R19: line field read/write, resets zero
// R20: software clears source before flag
// R21: events raise output only when enabled
// R22: each output ORs qualified mapped flags
module bridge_interrupt_and_iack_logic
  import bridge_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [NUM_EVT-1:0] event_pulse_i,
  input wire logic detected_parity_err_i,
  input wire logic signalled_system_err_i,
  input wire logic received_master_abort_i,
  input wire logic received_target_abort_i,
  input wire logic signalled_target_abort_i,
  input wire logic eeprom_load_i,
  input wire logic [7:0] eeprom_int_pin_i,
  output logic pci_int_o,
  output logic pci_int_oe_n_o,
  output logic local_bus_irq_out_n_o,
  input wire logic lb_ack_read_i,
  input wire logic [31:0] lb_ack_addr_i,
  input wire logic [1:0] transfer_size_bits_i,
  output logic lb_ack_retry_o,
  output logic lb_ack_done_o,
  output logic [31:0] lb_ack_data_o,
  output logic pci_ack_req_o,
  output logic [31:0] pci_ack_addr_o,
  output logic [3:0] pci_ack_be_n_o,
  input wire logic pci_ack_done_i,
  input wire logic [31:0] pci_ack_data_i,
  input wire logic pci_ack_rd_i,
  output logic pci_ack_rd_valid_o,
  output logic [31:0] pci_ack_rd_data_o
);

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic [NUM_SRC-1:0] enable;
  logic [NUM_SRC-1:0] dir_map;
  logic [NUM_SRC-1:0] flag;
  logic [NUM_SOFT-1:0] soft_req;
  logic [7:0] int_line;
  logic [7:0] int_pin;
  logic [31:0] ack_data;
  logic cfg_any;
  logic wr_ok;
  logic [CFG_BIT:0] evt_map;
  logic [NUM_SOFT-1:0] soft_map;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] clr_vec;
  logic [NUM_SRC-1:0] qual;
  logic [31:0] rd_word;
  logic rd_hit;
  ack_state_t ack_state;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  // upper address bits set: error answer, no register touched
  assign wr_ok = wr_fire && (aw_addr[31:ADDR_MSB+1] == '0);
  assign dir_map = {soft_map, evt_map};
  assign wr_ofs = {aw_addr[ADDR_MSB:ADDR_LSB], 2'h0};
  assign rd_ofs = {s_axi_araddr_i[ADDR_MSB:ADDR_LSB], 2'h0};

  // address and data may arrive in either order
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= WORD_ZERO;
      w_data <= WORD_ZERO;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (wr_ofs > OFS_ACK || aw_addr[31:ADDR_MSB+1] != '0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable <= SRC_ZERO;
      evt_map <= SRC_ZERO[CFG_BIT:0];
      soft_req <= '0;
      int_line <= INT_LINE_RST;
    end else if (wr_ok && w_strb[0]) begin
      if (wr_ofs == OFS_ENABLE) begin
        enable <= {SRC_ZERO[NUM_SRC-1:CFG_BIT+1], w_data[CFG_BIT:0]};
      end
      if (wr_ofs == OFS_DIR) begin
        evt_map <= w_data[CFG_BIT:0];
      end
      // R2 soft request bits
      if (wr_ofs == OFS_SOFT) begin
        soft_req <= w_data[NUM_SOFT-1:0];
      end
      // R19 line field plain read/write
      if (wr_ofs == OFS_MISC) begin
        int_line <= w_data[LINE_LSB +: FIELD_W];
      end
    end
  end

  // soft map bits sit in the second byte lane
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      soft_map <= '0;
    end else if (wr_ok && w_strb[1] && wr_ofs == OFS_DIR) begin
      soft_map <= w_data[NUM_SRC-1:SOFT_LSB];
    end
  end

  // R17 pin field resets to one
  // R18 eeprom load wins; local write may change it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_pin <= INT_PIN_RST;
    end else if (eeprom_load_i) begin
      int_pin <= eeprom_int_pin_i;
    end else if (wr_ok && w_strb[1] && wr_ofs == OFS_MISC) begin
      int_pin <= w_data[PIN_LSB +: FIELD_W];
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // R9 master parity bit has no input, kept out of cfg_any
  assign cfg_any = detected_parity_err_i | signalled_system_err_i | received_master_abort_i
                 | received_target_abort_i | signalled_target_abort_i;

  always_comb begin
    set_vec = SRC_ZERO;
    clr_vec = SRC_ZERO;
    // R1 event pulses set their flags
    set_vec[NUM_EVT-1:0] = event_pulse_i;
    // R7 any config error bit set
    // level, not edge: flag re-sets until the source is cleared
    set_vec[CFG_BIT] = cfg_any;
    // R3 writing a request bit sets its flag
    if (wr_ok && w_strb[0] && wr_ofs == OFS_SOFT) begin
      set_vec[NUM_SRC-1:SOFT_LSB] = w_data[NUM_SOFT-1:0];
    end
    // R5 R10 write one to clear, zero ignored
    if (wr_ok && wr_ofs == OFS_STATUS) begin
      clr_vec[CFG_BIT:0] = w_strb[0] ? w_data[CFG_BIT:0] : '0;
      clr_vec[NUM_SRC-1:SOFT_LSB] = w_strb[1] ? w_data[NUM_SRC-1:SOFT_LSB] : '0;
    end
  end

  // an event on the clear cycle survives: set wins
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          flag[i] <= 1'b0;
        end else if (set_vec[i]) begin
          flag[i] <= 1'b1;
        end else if (clr_vec[i]) begin
          flag[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // interrupt steering
  // ----------------------------------------
  // R21 events gated by enable; R4 soft flags ungated
  assign qual = flag & (enable | {{NUM_SOFT{1'b1}}, SRC_ZERO[SOFT_LSB-1:0]});

  // R22 R8 map one steers to pci pin, zero to local bus
  // R18 pin field never gates the pin driver
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pci_int_oe_n_o <= 1'b1;
      local_bus_irq_out_n_o <= 1'b1;
    end else begin
      pci_int_oe_n_o <= !(|(qual & dir_map));
      local_bus_irq_out_n_o <= !(|(qual & ~dir_map));
    end
  end

  // open drain: only ever pulls low
  assign pci_int_o = 1'b0;

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_comb begin
    rd_word = WORD_ZERO;
    rd_hit = (s_axi_araddr_i[31:ADDR_MSB+1] == '0);
    unique case (rd_ofs)
      OFS_ENABLE: rd_word[NUM_SRC-1:0] = enable;
      OFS_DIR: rd_word[NUM_SRC-1:0] = dir_map;
      OFS_STATUS: rd_word[NUM_SRC-1:0] = flag;
      OFS_SOFT: rd_word[NUM_SOFT-1:0] = soft_req;
      OFS_MISC: rd_word = {16'h0000, int_pin, int_line};
      OFS_ACK: rd_word = ack_data;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= WORD_ZERO;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_hit ? rd_word : WORD_ZERO;
      s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // acknowledge cycle generator
  // ----------------------------------------
  function automatic logic [3:0] lanes(input logic [1:0] transfer_size_bits, input logic [1:0] a);
    logic [3:0] m;
    begin
      unique case (transfer_size_bits)
        SIZE_LONG: m = LANE_LONG;
        SIZE_BYTE: m = LANE_BYTE;
        SIZE_HALF: m = LANE_HALF;
        default: m = LANE_TRI;
      endcase
      lanes = 4'(m << a);
    end
  endfunction

  // R6 this machine never looks at interrupt state
  // R14 retry until data latched, then return it
  // R15 relies on the local master repeating the read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_state <= ACK_IDLE;
      lb_ack_retry_o <= 1'b0;
      lb_ack_done_o <= 1'b0;
      lb_ack_data_o <= WORD_ZERO;
      pci_ack_req_o <= 1'b0;
      pci_ack_addr_o <= WORD_ZERO;
      pci_ack_be_n_o <= 4'hF;
      ack_data <= WORD_ZERO;
    end else begin
      lb_ack_retry_o <= 1'b0;
      lb_ack_done_o <= 1'b0;
      unique case (ack_state)
        ACK_IDLE: begin
          if (lb_ack_read_i) begin
            // R11 read launches the pci cycle
            ack_state <= ACK_BUSY;
            lb_ack_retry_o <= 1'b1;
            pci_ack_req_o <= 1'b1;
            // R13 address passed through unchanged
            pci_ack_addr_o <= lb_ack_addr_i;
            // R12 lanes from size and low address
            pci_ack_be_n_o <= ~lanes(transfer_size_bits_i, lb_ack_addr_i[1:0]);
          end
        end
        ACK_BUSY: begin
          lb_ack_retry_o <= lb_ack_read_i;
          if (pci_ack_done_i) begin
            ack_state <= ACK_READY;
            pci_ack_req_o <= 1'b0;
            ack_data <= pci_ack_data_i;
          end
        end
        ACK_READY: begin
          if (lb_ack_read_i) begin
            ack_state <= ACK_IDLE;
            lb_ack_done_o <= 1'b1;
            lb_ack_data_o <= ack_data;
          end
        end
      endcase
    end
  end

  // R16 pci side reads zero, starts nothing
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pci_ack_rd_valid_o <= 1'b0;
      pci_ack_rd_data_o <= WORD_ZERO;
    end else begin
      pci_ack_rd_valid_o <= pci_ack_rd_i;
      pci_ack_rd_data_o <= WORD_ZERO;
    end
  end

endmodule // bridge_interrupt_and_iack_logic

// >>> hdl/bridge_irq_pkg.sv
/*
  constants shared by the bridge interrupt and acknowledge logic.
  assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
*/
package bridge_irq_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SOFT = 8'h0C;
  localparam logic [7:0] OFS_MISC = 8'h10;
  localparam logic [7:0] OFS_ACK = 8'h14;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int NUM_EVT = 7;
  localparam int NUM_SOFT = 4;
  localparam int CFG_BIT = 7;
  localparam int SOFT_LSB = 8;
  localparam int NUM_SRC = 12;
  localparam int LINE_LSB = 0;
  localparam int PIN_LSB = 8;
  localparam int FIELD_W = 8;
  // ----------------------------------------
  // reset values and answers
  // ----------------------------------------
  localparam logic [NUM_SRC-1:0] SRC_ZERO = 12'h000;
  localparam logic [7:0] INT_LINE_RST = 8'h00;
  localparam logic [7:0] INT_PIN_RST = 8'h01;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // transfer size code: 00 long, 01 byte, 10 half, 11 three bytes
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
  localparam logic [3:0] LANE_LONG = 4'hF;
  localparam logic [3:0] LANE_BYTE = 4'h1;
  localparam logic [3:0] LANE_HALF = 4'h3;
  localparam logic [3:0] LANE_TRI = 4'h7;
  // acknowledge cycle sequencing
  typedef enum logic [1:0] {
    ACK_IDLE,
    ACK_BUSY,
    ACK_READY
  } ack_state_t;
endpackage
